// ===== verilog/cbm_defines.svh
// Constants of the branch, bit and move execute block
`ifndef CBM_DEFINES_SVH
`define CBM_DEFINES_SVH

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define CBM_FLAG_C 3'd0
`define CBM_FLAG_Z 3'd1
`define CBM_FLAG_N 3'd2
`define CBM_FLAG_V 3'd3
`define CBM_FLAG_S 3'd4
`define CBM_FLAG_H 3'd5
`define CBM_FLAG_T 3'd6
`define CBM_FLAG_I 3'd7

// ----------------------------------------------------------------
// Pointer pairs, reset values, offsets
// ----------------------------------------------------------------
`define CBM_PTR_X_LO   5'd26
`define CBM_PTR_Y_LO   5'd28
`define CBM_STATUS_REGISTER_RESET 8'h00
`define CBM_PC_RESET   16'h0000
`define CBM_OFS_STATUS 8'h00
`define CBM_OFS_PC_LO  8'h01
`define CBM_OFS_PC_HI  8'h02
`define CBM_OFS_STATE  8'h03
`define CBM_OFFSET_W   7
`define CBM_IO_AW      5

`endif

// ===== verilog/cbm_pkg.sv
// Types and shared decode helpers of the execute block
`include "cbm_defines.svh"

package cbm_pkg;

  // ----------------------------------------------------------------
  // Sizes and enumerations
  // ----------------------------------------------------------------
  localparam int CBM_REG_AW = 5;
  localparam int CBM_DATA_W = 8;

  typedef enum logic [4:0] {
    cbm_nop,
    cbm_branch_unsigned_ge, cbm_branch_unsigned_lt, cbm_branch_negative,
    cbm_branch_nonnegative, cbm_branch_signed_ge, cbm_branch_signed_lt,
    cbm_branch_halfcarry_on, cbm_branch_halfcarry_off, cbm_branch_tflag_on,
    cbm_branch_tflag_off, cbm_branch_overflow_on, cbm_branch_overflow_off,
    cbm_branch_irq_enabled, cbm_branch_irq_disabled,
    cbm_io_bit_set, cbm_io_bit_clear,
    cbm_logical_shift_left, cbm_logical_shift_right,
    cbm_rotate_left_carry, cbm_arith_shift_right,
    cbm_flag_set, cbm_flag_clear, cbm_global_irq_on, cbm_global_irq_off,
    cbm_bit_to_tflag, cbm_tflag_to_bit,
    cbm_register_copy, cbm_register_pair_copy, cbm_immediate_load,
    cbm_pointer_load
  } cbm_op_t;

  typedef enum logic [1:0] {cbm_ld_plain, cbm_ld_postinc, cbm_ld_predec} cbm_ld_mode_t;

  typedef enum logic [1:0] {cbm_s_idle, cbm_s_br_taken, cbm_s_io_wb, cbm_s_ld_wb} cbm_state_t;

  // ----------------------------------------------------------------
  // Branch decode
  // ----------------------------------------------------------------
  function automatic logic cbm_is_branch(cbm_op_t op);
    return op inside {[cbm_branch_unsigned_ge:cbm_branch_irq_disabled]};
  endfunction

  function automatic logic cbm_branch_hit(cbm_op_t op, logic [7:0] sr);
    logic nv;
    nv = sr[`CBM_FLAG_N] ^ sr[`CBM_FLAG_V];
    case (op)
      cbm_branch_unsigned_ge:   return !sr[`CBM_FLAG_C];
      cbm_branch_unsigned_lt:   return sr[`CBM_FLAG_C];
      cbm_branch_negative:      return sr[`CBM_FLAG_N];
      cbm_branch_nonnegative:   return !sr[`CBM_FLAG_N];
      cbm_branch_signed_ge:     return !nv;
      cbm_branch_signed_lt:     return nv;
      cbm_branch_halfcarry_on:  return sr[`CBM_FLAG_H];
      cbm_branch_halfcarry_off: return !sr[`CBM_FLAG_H];
      cbm_branch_tflag_on:      return sr[`CBM_FLAG_T];
      cbm_branch_tflag_off:     return !sr[`CBM_FLAG_T];
      cbm_branch_overflow_on:   return sr[`CBM_FLAG_V];
      cbm_branch_overflow_off:  return !sr[`CBM_FLAG_V];
      cbm_branch_irq_enabled:   return sr[`CBM_FLAG_I];
      cbm_branch_irq_disabled:  return !sr[`CBM_FLAG_I];
      default:                  return 1'b0;
    endcase
  endfunction

endpackage

// ===== verilog/cbm_rf_if.sv
// Carrier between the execute core and its register file
`timescale 1ns/100ps

interface cbm_rf_if;
  import cbm_pkg::*;
  logic [CBM_REG_AW-1:0]   rd_a_idx;
  logic [CBM_REG_AW-1:0]   rd_b_idx;
  logic [CBM_REG_AW-1:0]   rd_w_idx;
  logic [CBM_DATA_W-1:0]   rd_a;
  logic [CBM_DATA_W-1:0]   rd_b;
  logic [2*CBM_DATA_W-1:0] rd_w;
  logic                    wb_en;
  logic [CBM_REG_AW-1:0]   wb_idx;
  logic [CBM_DATA_W-1:0]   wb_data;
  logic                    ww_en;
  logic [CBM_REG_AW-1:0]   ww_idx;
  logic [2*CBM_DATA_W-1:0] ww_data;

  modport core (output rd_a_idx, rd_b_idx, rd_w_idx, wb_en, wb_idx, wb_data,
                output ww_en, ww_idx, ww_data, input rd_a, rd_b, rd_w);
  modport store (input rd_a_idx, rd_b_idx, rd_w_idx, wb_en, wb_idx, wb_data,
                 input ww_en, ww_idx, ww_data, output rd_a, rd_b, rd_w);
endinterface

// ===== verilog/cbm_regfile.sv
// General purpose register file: two byte reads, one pair read, byte and pair writes
`timescale 1ns/100ps

module cbm_regfile
  import cbm_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  cbm_rf_if.store  rf
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DEPTH != (1 << CBM_REG_AW)) begin : g_bad_depth
    $error("Register file depth must match the index width");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [CBM_DATA_W-1:0] mem      [DEPTH];
  logic [CBM_DATA_W-1:0] next_mem [DEPTH];

  // Byte write follows the pair write, so a byte write wins on overlap
  always_comb begin
    next_mem = mem;
    if (rf.ww_en) begin
      next_mem[{rf.ww_idx[CBM_REG_AW-1:1], 1'b0}] = rf.ww_data[CBM_DATA_W-1:0];
      next_mem[{rf.ww_idx[CBM_REG_AW-1:1], 1'b1}] = rf.ww_data[2*CBM_DATA_W-1:CBM_DATA_W];
    end
    if (rf.wb_en) begin
      next_mem[rf.wb_idx] = rf.wb_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign rf.rd_a = mem[rf.rd_a_idx];
  assign rf.rd_b = mem[rf.rd_b_idx];
  assign rf.rd_w = {mem[{rf.rd_w_idx[CBM_REG_AW-1:1], 1'b1}],
                    mem[{rf.rd_w_idx[CBM_REG_AW-1:1], 1'b0}]};

endmodule

// ===== verilog/cbm_exec.sv
// Execute block for flag branches, bit operations, shifts, moves and pointer loads
//
// Operation
// - Carry and sign branches jump to pc plus offset plus one, one or two cycles.
// - Signed branches test negative xor overflow: zero for ge, one for lt.
// - Half-carry branches jump on flag one or zero, leaving every flag alone.
// - T-flag branches jump when the T flag equals the tested value.
// - Overflow branches jump on overflow one or zero, flags unchanged.
// - Interrupt-state branches test the global enable, taken on one or zero.
// - I/O bit set and clear force one bit, two cycles, no flags.
// - Logical shifts insert zero, update zero, carry, negative, overflow in one cycle.
// - Rotate left pulls old carry into bit 0, bit 7 into carry.
// - Arithmetic shift right moves bits down one, updates four flags, one cycle.
// - Single-cycle instructions set or clear exactly one named status flag.
// - Global interrupt on and off write the interrupt flag in one cycle.
// - Bit store copies a selected register bit into the T flag.
// - Bit load writes the T flag into a selected register bit.
// - Register copy, pair copy and immediate load take one cycle, no flags.
// - Pointer loads read memory at X or Y in two cycles; plain or post-increment.
// - Pre-decrement loads lower the pointer first, then read there; two cycles.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "cbm_defines.svh"

module cbm_exec
  import cbm_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     op_valid,
  output logic                          op_ready,
  input  wire cbm_op_t                  op_code,
  input  wire logic [4:0]               op_rd,
  input  wire logic [4:0]               op_rr,
  input  wire logic [2:0]               op_bit,
  input  wire logic [7:0]               op_imm,
  input  wire logic                     op_ptr_y,
  input  wire cbm_ld_mode_t             op_ld_mode,
  output logic [PC_W-1:0]               pc,
  output logic [7:0]                    status_register,
  output logic [15:0]                   dmem_addr,
  output logic                          dmem_rd,
  input  wire logic [7:0]               dmem_rdata,
  output logic [`CBM_IO_AW-1:0]         io_addr,
  output logic                          io_rd,
  input  wire logic [7:0]               io_rdata,
  output logic                          io_wr,
  output logic [7:0]                    io_wdata,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [7:0]                    reg_rdata
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (PC_W < 8 || PC_W > 16) begin : g_bad_pc
    $error("Program counter width must lie between 8 and 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbm_state_t             state;
  cbm_state_t             next_state;
  logic [PC_W-1:0]        next_pc;
  logic [7:0]             next_status_register;
  logic [4:0]             hold_rd;
  logic [4:0]             next_hold_rd;
  logic [2:0]             hold_bit;
  logic [2:0]             next_hold_bit;
  logic [`CBM_IO_AW-1:0]  hold_io;
  logic [`CBM_IO_AW-1:0]  next_hold_io;
  logic                   hold_set;
  logic                   next_hold_set;
  logic [7:0]             next_reg_rdata;
  logic [PC_W-1:0]        branch_offset;
  logic [15:0]            ptr_now;
  logic [7:0]             bit_mask;
  logic [7:0]             hold_mask;

  cbm_rf_if rf ();

  cbm_regfile #(
    .DEPTH (32)
  ) u_regfile (
    .clock (clock),
    .rstn  (rstn),
    .rf    (rf)
  );

  // Flags after a shift; the signed flag is deliberately left alone
  function automatic logic [7:0] shift_flags(logic [7:0] sr, logic [7:0] res, logic cout);
    logic [7:0] s;
    s = sr;
    s[`CBM_FLAG_C] = cout;
    s[`CBM_FLAG_Z] = (res == 8'h00);
    s[`CBM_FLAG_N] = res[7];
    s[`CBM_FLAG_V] = res[7] ^ cout;
    return s;
  endfunction

  assign op_ready      = (state == cbm_s_idle);
  assign branch_offset = PC_W'({{(PC_W - `CBM_OFFSET_W){op_imm[6]}}, op_imm[6:0]});
  assign ptr_now       = rf.rd_w;
  assign bit_mask      = 8'h01 << op_bit;
  assign hold_mask     = 8'h01 << hold_bit;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_pc              = pc;
    next_status_register = status_register;
    next_hold_rd         = hold_rd;
    next_hold_bit        = hold_bit;
    next_hold_io         = hold_io;
    next_hold_set        = hold_set;
    rf.rd_a_idx          = op_rd;
    rf.rd_b_idx          = op_rr;
    rf.rd_w_idx          = (op_code == cbm_register_pair_copy) ? op_rr :
                           (op_ptr_y ? `CBM_PTR_Y_LO : `CBM_PTR_X_LO);
    rf.wb_en             = 1'b0;
    rf.wb_idx            = op_rd;
    rf.wb_data           = 8'h00;
    rf.ww_en             = 1'b0;
    rf.ww_idx            = op_rd;
    rf.ww_data           = 16'h0000;
    dmem_rd              = 1'b0;
    dmem_addr            = ptr_now;
    io_rd                = 1'b0;
    io_wr                = 1'b0;
    io_addr              = op_imm[`CBM_IO_AW-1:0];
    io_wdata             = 8'h00;
    unique case (state)
      cbm_s_idle: begin
        if (op_valid) begin
          next_pc = pc + PC_W'(1);
          if (cbm_is_branch(op_code)) begin
            // Taken branch spends a second cycle refilling
            if (cbm_branch_hit(op_code, status_register)) begin
              next_pc    = pc + PC_W'(1) + branch_offset;
              next_state = cbm_s_br_taken;
            end
          end else begin
            case (op_code)
              cbm_io_bit_set, cbm_io_bit_clear: begin
                io_rd         = 1'b1;
                next_hold_io  = op_imm[`CBM_IO_AW-1:0];
                next_hold_bit = op_bit;
                next_hold_set = (op_code == cbm_io_bit_set);
                next_state    = cbm_s_io_wb;
              end
              cbm_logical_shift_left: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = {rf.rd_a[6:0], 1'b0};
                next_status_register = shift_flags(status_register, rf.wb_data, rf.rd_a[7]);
              end
              cbm_logical_shift_right: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = {1'b0, rf.rd_a[7:1]};
                next_status_register = shift_flags(status_register, rf.wb_data, rf.rd_a[0]);
              end
              cbm_rotate_left_carry: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = {rf.rd_a[6:0], status_register[`CBM_FLAG_C]};
                next_status_register = shift_flags(status_register, rf.wb_data, rf.rd_a[7]);
              end
              cbm_arith_shift_right: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = {rf.rd_a[7], rf.rd_a[7:1]};
                next_status_register = shift_flags(status_register, rf.wb_data, rf.rd_a[0]);
              end
              cbm_flag_set: begin
                next_status_register = status_register | bit_mask;
              end
              cbm_flag_clear: begin
                next_status_register = status_register & ~bit_mask;
              end
              cbm_global_irq_on: begin
                next_status_register[`CBM_FLAG_I] = 1'b1;
              end
              cbm_global_irq_off: begin
                next_status_register[`CBM_FLAG_I] = 1'b0;
              end
              cbm_bit_to_tflag: begin
                next_status_register[`CBM_FLAG_T] = rf.rd_b[op_bit];
              end
              cbm_tflag_to_bit: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = (rf.rd_a & ~bit_mask) |
                             (status_register[`CBM_FLAG_T] ? bit_mask : 8'h00);
              end
              cbm_register_copy: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = rf.rd_b;
              end
              cbm_register_pair_copy: begin
                rf.ww_en   = 1'b1;
                rf.ww_data = rf.rd_w;
              end
              cbm_immediate_load: begin
                rf.wb_en   = 1'b1;
                rf.wb_data = op_imm;
              end
              cbm_pointer_load: begin
                // Pointer moves now unless the mode is plain, the data lands in the second cycle
                dmem_rd      = 1'b1;
                next_hold_rd = op_rd;
                rf.ww_idx    = rf.rd_w_idx;
                next_state   = cbm_s_ld_wb;
                if (op_ld_mode == cbm_ld_predec) begin
                  dmem_addr  = ptr_now - 16'h0001;
                  rf.ww_en   = 1'b1;
                  rf.ww_data = ptr_now - 16'h0001;
                end else if (op_ld_mode == cbm_ld_postinc) begin
                  rf.ww_en   = 1'b1;
                  rf.ww_data = ptr_now + 16'h0001;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      cbm_s_br_taken: begin
        next_state = cbm_s_idle;
      end
      cbm_s_io_wb: begin
        io_wr      = 1'b1;
        io_addr    = hold_io;
        io_wdata   = hold_set ? (io_rdata | hold_mask) : (io_rdata & ~hold_mask);
        next_state = cbm_s_idle;
      end
      cbm_s_ld_wb: begin
        rf.wb_en   = 1'b1;
        rf.wb_idx  = hold_rd;
        rf.wb_data = dmem_rdata;
        next_state = cbm_s_idle;
      end
    endcase
    // Software write to the status register overrides the instruction
    if (reg_wr && reg_addr == `CBM_OFS_STATUS) begin
      next_status_register = reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `CBM_OFS_STATUS: next_reg_rdata = status_register;
        `CBM_OFS_PC_LO:  next_reg_rdata = pc[7:0];
        `CBM_OFS_PC_HI:  next_reg_rdata = 8'(pc >> 8);
        `CBM_OFS_STATE:  next_reg_rdata = 8'(state);
        default:         next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state           <= cbm_s_idle;
      pc              <= PC_W'(`CBM_PC_RESET);
      status_register <= `CBM_STATUS_REGISTER_RESET;
      hold_rd         <= 5'h00;
      hold_bit        <= 3'h0;
      hold_io         <= '0;
      hold_set        <= 1'b0;
      reg_rdata       <= 8'h00;
    end else begin
      state           <= next_state;
      pc              <= next_pc;
      status_register <= next_status_register;
      hold_rd         <= next_hold_rd;
      hold_bit        <= next_hold_bit;
      hold_io         <= next_hold_io;
      hold_set        <= next_hold_set;
      reg_rdata       <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence accept_s(cbm_op_t op);
    state == cbm_s_idle && op_valid && op_code == op && !reg_wr;
  endsequence

  sequence br_taken_s;
    state == cbm_s_idle && op_valid && cbm_is_branch(op_code) &&
      cbm_branch_hit(op_code, status_register);
  endsequence

  br_taken_target_a: assert property (br_taken_s |=> !op_ready && pc ==
    $past(pc) + PC_W'(1) + $past(branch_offset) ##1 op_ready)
    else $error("Taken branch target or timing wrong");

  br_not_taken_a: assert property (
    state == cbm_s_idle && op_valid && cbm_is_branch(op_code) &&
    !cbm_branch_hit(op_code, status_register) |=> op_ready && pc == $past(pc) + PC_W'(1))
    else $error("Untaken branch must take one cycle");

  signed_branch_a: assert property (
    state == cbm_s_idle && op_valid && op_code == cbm_branch_signed_lt |=>
    (state == cbm_s_br_taken) ==
      ($past(status_register[`CBM_FLAG_N]) ^ $past(status_register[`CBM_FLAG_V])))
    else $error("Signed branch ignores negative xor overflow");

  branch_flags_a: assert property (br_taken_s and !reg_wr |=>
    $stable(status_register))
    else $error("Branch changed a flag");

  io_rmw_a: assert property (accept_s(cbm_io_bit_set) |-> io_rd ##1
    io_wr && io_addr == $past(op_imm[`CBM_IO_AW-1:0]) && io_wdata[hold_bit] ##1 op_ready)
    else $error("I/O bit set sequence wrong");

  shift_left_a: assert property (accept_s(cbm_logical_shift_left) |=>
    status_register[`CBM_FLAG_C] == $past(rf.rd_a[7]) &&
    status_register[`CBM_FLAG_Z] == ($past(rf.rd_a[6:0]) == 7'h00))
    else $error("Shift left flags wrong");

  asr_sign_a: assert property (accept_s(cbm_arith_shift_right) |->
    rf.wb_en && rf.wb_data[7] == rf.rd_a[7] ##1 status_register[`CBM_FLAG_C] == $past(rf.rd_a[0]))
    else $error("Arithmetic shift lost the sign or carry");

  flag_set_a: assert property (accept_s(cbm_flag_set) |=>
    status_register == ($past(status_register) | (8'h01 << $past(op_bit))))
    else $error("Flag set touched another flag");

  bit_store_a: assert property (accept_s(cbm_bit_to_tflag) |=>
    status_register[`CBM_FLAG_T] == $past(rf.rd_b[op_bit]) && op_ready)
    else $error("Bit store did not reach the T flag");

  predec_load_a: assert property (
    accept_s(cbm_pointer_load) and op_ld_mode == cbm_ld_predec |->
    dmem_rd && dmem_addr == ptr_now - 16'h0001 ##1 rf.wb_en && rf.wb_idx == $past(op_rd))
    else $error("Pre-decrement load address or write-back wrong");

endmodule

// ===== verif/cbm_mem_model.sv
// Data memory and I/O space that answer the execute block one cycle late
`timescale 1ns/100ps

module cbm_mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] dmem_addr,
  input  wire logic        dmem_rd,
  output logic [7:0]       dmem_rdata,
  input  wire logic [4:0]  io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata
);
  logic [7:0] io_mem [32];

  initial begin
    dmem_rdata = 8'h00;
    io_rdata = 8'h00;
    for (int i = 0; i < 32; i++) io_mem[i] = 8'(i) ^ 8'ha5;
  end

  // Outside the answer cycle the lines flip, so a late sample never matches
  always @(posedge clock) begin
    dmem_rdata <= dmem_rd ? (dmem_addr[7:0] ^ 8'h5a) : ~dmem_rdata;
    io_rdata <= io_rd ? io_mem[io_addr] : ~io_rdata;
    if (io_wr) io_mem[io_addr] <= io_wdata;
  end
endmodule

// ===== verif/cbm_exec_tb.sv
// Self-checking bench of the execute block
`timescale 1ns/100ps

module cbm_exec_tb;
  import cbm_pkg::*;
  logic clock = 0, rstn = 0, op_valid = 0, op_ptr_y = 0, op_ready, dmem_rd, io_rd, io_wr;
  logic reg_wr = 0, reg_rd = 0, tk;
  cbm_op_t op_code = cbm_nop;
  cbm_ld_mode_t op_ld_mode = cbm_ld_plain;
  logic [4:0] op_rd = 0, op_rr = 0, io_addr;
  logic [2:0] op_bit = 0;
  logic [7:0] op_imm = 0, reg_addr = 0, reg_wdata = 0, reg_rdata, status_register;
  logic [7:0] dmem_rdata, io_rdata, io_wdata, sv;
  logic [15:0] pc, dmem_addr, ep, seen;
  int i, k, cyc, failures = 0, comparisons = 0;
  cbm_op_t sc [4] = '{cbm_logical_shift_left, cbm_logical_shift_right,
                      cbm_rotate_left_carry, cbm_arith_shift_right};
  logic [7:0] vin [4] = '{8'h81, 8'h01, 8'h80, 8'h81};
  logic [7:0] sb [4] = '{8'hf0, 8'hf0, 8'hf1, 8'hf0};
  logic [7:0] sa [4] = '{8'hf9, 8'hfb, 8'hf9, 8'hf5};
  logic [7:0] sr [4] = '{8'h02, 8'h00, 8'h01, 8'hc0};
  logic py [5] = '{1, 1, 1, 0, 0};
  cbm_ld_mode_t md [5] = '{cbm_ld_predec, cbm_ld_postinc, cbm_ld_plain, cbm_ld_postinc, cbm_ld_plain};
  logic [15:0] ea [5] = '{16'h003f, 16'h003f, 16'h0040, 16'h0040, 16'h0041};

  always #5 clock = ~clock;
  always @(posedge clock) if (dmem_rd) seen <= dmem_addr;

  cbm_exec DUT (.clock(clock), .rstn(rstn), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_rd(op_rd), .op_rr(op_rr), .op_bit(op_bit), .op_imm(op_imm),
    .op_ptr_y(op_ptr_y), .op_ld_mode(op_ld_mode), .pc(pc), .status_register(status_register),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .io_addr(io_addr),
    .io_rd(io_rd), .io_rdata(io_rdata), .io_wr(io_wr), .io_wdata(io_wdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  cbm_mem_model mem (.clock(clock), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata));

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is sampled just after each edge, once the state register has landed
  task automatic op(input cbm_op_t c, input logic [4:0] rd, input logic [4:0] rr,
                    input logic [2:0] b, input logic [7:0] imm, input logic y = 1'b0,
                    input cbm_ld_mode_t m = cbm_ld_plain);
    @(posedge clock);
    op_code <= c; op_rd <= rd; op_rr <= rr; op_bit <= b; op_imm <= imm;
    op_ptr_y <= y; op_ld_mode <= m; op_valid <= 1'b1;
    @(posedge clock);
    op_valid <= 1'b0;
    cyc = 0;
    #1;
    while (!op_ready && cyc < 8) begin
      cyc++;
      @(posedge clock);
      #1;
    end
    if (cyc == 8) begin
      failures++;
      close_out;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    chk(pc, 16'h0000);
    reg_read(8'h00, 8'h00);
    reg_read(8'h10, 8'h00);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      op(cbm_flag_set, 0, 0, i[2:0], 0); chk(status_register, 8'h01 << i);
      op(cbm_flag_clear, 0, 0, i[2:0], 0); chk(status_register, 8'h00);
    end
    op(cbm_global_irq_on, 0, 0, 0, 0); chk(status_register, 8'h80);
    op(cbm_global_irq_off, 0, 0, 0, 0); chk(status_register, 8'h00);
    $display("test flags done");
    for (i = 0; i < 28; i++) begin
      sv = i[0] ? 8'he5 : 8'h08;
      k = i >> 1;
      tk = ((i[0] ? 14'h1966 : 14'h26a9) >> k) & 14'h1;
      reg_write(8'h00, sv);
      ep = pc + 16'h1 + (tk ? (k[0] ? 16'hfffd : 16'h0005) : 16'h0);
      op(cbm_op_t'(5'(k + 1)), 0, 0, 0, k[0] ? 8'h7d : 8'h05);
      chk(pc, ep);
      chk(status_register, sv);
      chk(16'(cyc), {15'h0, tk});
    end
    $display("test branches done");
    for (i = 0; i < 4; i++) begin
      op(cbm_immediate_load, 16, 0, 0, vin[i]);
      reg_write(8'h00, sb[i]);
      op(sc[i], 16, 0, 0, 0); chk(status_register, sa[i]);
      chk(16'(cyc), 16'h0);
      chk(DUT.u_regfile.mem[16], sr[i]);
    end
    $display("test shifts done");
    op(cbm_immediate_load, 17, 0, 0, 8'h20);
    op(cbm_register_copy, 18, 17, 0, 0); chk(16'(cyc), 16'h0);
    reg_write(8'h00, 8'h00);
    op(cbm_bit_to_tflag, 0, 18, 5, 0); chk(status_register, 8'h40);
    op(cbm_tflag_to_bit, 19, 0, 2, 0); chk(status_register, 8'h40);
    op(cbm_flag_clear, 0, 0, 6, 0);
    op(cbm_bit_to_tflag, 0, 19, 2, 0); chk(status_register, 8'h40);
    op(cbm_immediate_load, 26, 0, 0, 8'h40);
    op(cbm_register_pair_copy, 28, 26, 0, 0);
    for (i = 0; i < 5; i++) begin
      op(cbm_pointer_load, 16, 0, 0, 0, py[i], md[i]); chk(seen, ea[i]);
      chk(16'(cyc), 16'h1);
      chk(DUT.u_regfile.mem[16], ea[i][7:0] ^ 8'h5a);
    end
    chk({DUT.u_regfile.mem[29], DUT.u_regfile.mem[28]}, 16'h0040);
    chk({DUT.u_regfile.mem[27], DUT.u_regfile.mem[26]}, 16'h0041);
    op(cbm_flag_clear, 0, 0, 6, 0);
    op(cbm_bit_to_tflag, 0, 16, 0, 0); chk(status_register, 8'h40);
    $display("test moves and loads done");
    op(cbm_io_bit_set, 0, 0, 4, 8'h03); chk(mem.io_mem[3], 8'hb6);
    chk(16'(cyc), 16'h1);
    op(cbm_io_bit_clear, 0, 0, 1, 8'h03); chk(mem.io_mem[3], 8'hb4);
    reg_read(8'h00, 8'h40);
    reg_read(8'h03, 8'h00);
    $display("test io done");
    close_out;
  end
endmodule
